// ==== bench/shift_spi_bench.sv ====
// Self-checking bench for the serial shifter with SPI pins
`timescale 1ns/10ps
`include "shift_spi_defines.svh"

module shift_spi_bench;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       subsystem_clock = 1'b0;
    logic       irq_gate = 1'b0;
    logic       sclk_o, sclk_oe, peer_sclk, peer_mosi, sclk_pin;
    logic       dout_o, dout_oe, irq_o;
    int         n_fail = 0;
    int         check_count = 0;

    // Clocks: system 8 ns, link source 80 ns
    always #4 clk_sys = ~clk_sys;
    always #40 subsystem_clock = ~subsystem_clock;

    // Pin level: the design wins while it drives the clock pin
    assign sclk_pin = sclk_oe ? sclk_o : peer_sclk;

    shift_spi u_dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .aux_clk(1'b0),
        .subsystem_clock(subsystem_clock), .timer_out(4'h0),
        .global_irq_enable(irq_gate), .sclk_i(sclk_pin),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .din_i(peer_mosi),
        .dout_o(dout_o), .dout_oe(dout_oe), .irq_o(irq_o)
    );

    spi_far_master u_peer (
        .sclk(peer_sclk), .mosi(peer_mosi), .miso(dout_o)
    );

    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe edge
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        rd(`OFF_CTRL0, `RST_CTRL0);
        rd(`OFF_CTRL1, `RST_CTRL1);
        rd(`OFF_CLKCTL, `RST_CLKCTL);
        wr(`OFF_STATUS, 8'hFF);
        rd(`OFF_STATUS, 8'h00);
        rd(3'h7, 8'h00);
    endtask : test_reset

    task automatic test_flag;
        wr(`OFF_CTRL0, 8'hE2);
        wr(`OFF_COUNT, 8'h00);
        rd(`OFF_CTRL1, 8'h01);
        wr(`OFF_COUNT, 8'h03);
        rd(`OFF_CTRL1, 8'h00);
        wr(`OFF_CTRL1, 8'h09);
        wr(`OFF_COUNT, 8'h05);
        rd(`OFF_CTRL1, 8'h09);
        wr(`OFF_CTRL0, 8'hE3);
        rd(`OFF_CTRL1, 8'h08);
        rd(`OFF_COUNT, 8'h05);
        wr(`OFF_CTRL0, 8'hE2);
        wr(`OFF_CTRL1, 8'h90);
    endtask : test_flag

    task automatic test_slave;
        logic [7:0] rx;
        wr(`OFF_CLKCTL, 8'h00);
        wr(`OFF_SHIFT_LOW, 8'hA5);
        wr(`OFF_COUNT, 8'h08);
        irq_gate <= 1'b1;
        settle(3);
        chk({7'h00, dout_o}, 8'h01);
        chk({7'h00, dout_oe}, 8'h01);
        chk({7'h00, sclk_oe}, 8'h00);
        u_peer.frame(8'h3C, 40, rx);
        settle(6);
        chk(rx, 8'hA5);
        rd(`OFF_SHIFT_LOW, 8'h3C);
        rd(`OFF_SHIFT_HIGH, 8'h00);
        rd(`OFF_CTRL1, 8'h91);
        chk({7'h00, irq_o}, 8'h01);
        // Clocks with the count at zero must not shift
        u_peer.frame(8'hFF, 40, rx);
        settle(6);
        rd(`OFF_COUNT, 8'h00);
        rd(`OFF_SHIFT_LOW, 8'h3C);
        wr(`OFF_CTRL0, 8'hE0);
        settle(3);
        chk({7'h00, dout_oe}, 8'h00);
    endtask : test_slave

    task automatic test_master;
        int n;
        // Done kept set so that the count write must clear it
        wr(`OFF_CTRL1, 8'h11);
        wr(`OFF_CTRL0, 8'hEA);
        wr(`OFF_CLKCTL, 8'h06);
        settle(1);
        chk({7'h00, irq_o}, 8'h01);
        wr(`OFF_COUNT, 8'h08);
        settle(4);
        chk({7'h00, irq_o}, 8'h00);
        chk({7'h00, sclk_oe}, 8'h01);
        n = 0;
        while (irq_o !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // Fifteen source edges at divide one, plus sync slack
        chk({7'h00, n >= 50 && n <= 100}, 8'h01);
        settle(20);
        chk({7'h00, sclk_o}, 8'h01);
        rd(`OFF_COUNT, 8'h00);
        rd(`OFF_SHIFT_LOW, 8'h00);
        // Clock pin must rest while done stays set
        n = 0;
        repeat (40) begin
            settle(1);
            n += (sclk_o !== 1'b1);
        end
        chk(8'(n), 8'h00);
    endtask : test_master

    // Soft clock, divide by two, wide LSB first, transparent latch
    task automatic test_soft;
        wr(`OFF_CTRL1, 8'h20);
        wr(`OFF_CTRL0, 8'hFE);
        wr(`OFF_CLKCTL, 8'h30);
        wr(`OFF_SHIFT_LOW, 8'h01);
        wr(`OFF_SHIFT_HIGH, 8'h80);
        settle(2);
        chk({7'h00, dout_o}, 8'h01);
        wr(`OFF_COUNT, 8'h02);
        repeat (2) begin
            wr(`OFF_CLKCTL, 8'h31);
            wr(`OFF_CLKCTL, 8'h30);
        end
        settle(4);
        rd(`OFF_COUNT, 8'h01);
        chk({7'h00, dout_o}, 8'h00);
        wr(`OFF_CLKCTL, 8'h31);
        wr(`OFF_CLKCTL, 8'h30);
        settle(4);
        rd(`OFF_CTRL1, 8'h21);
        rd(`OFF_SHIFT_HIGH, 8'h20);
        rd(`OFF_SHIFT_LOW, 8'h00);
        wr(`OFF_CTRL1, 8'h60);
        wr(`OFF_CTRL0, 8'hFF);
        settle(2);
        chk({7'h00, sclk_oe}, 8'h00);
    endtask : test_soft

    // ------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset();
        test_flag();
        test_slave();
        test_master();
        test_soft();
        finish_test();
    end

    // Whole run is a few hundred cycles; cut a hang well past it
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule : shift_spi_bench

// ==== bench/spi_far_master.sv ====
// Behavioural SPI master standing on the serial pins of the shifter
`timescale 1ns/10ps

module spi_far_master (
    // Serial pins seen from the far side
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    // Idle clock low; polarity zero on this link
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // far clock: clock only inside a frame, half period as given
    // edge use: change on leading edge, sample on trailing edge
    task automatic frame(input logic [7:0] tx, input int half,
                         output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            #(half);
            sclk = 1'b0;
            rx[i] = miso;
            #(half);
        end
        // Released line shows the inverse, never a stale level
        mosi = ~mosi;
    endtask : frame
endmodule : spi_far_master

// ==== core/shift_spi.sv ====
// Serial shift register with bit counter, clock generator and SPI pins
`timescale 1ns/10ps
`include "shift_spi_defines.svh"

module shift_spi (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Clock sources and global interrupt enable from outside
    input  wire logic       aux_clk,
    input  wire logic       subsystem_clock,
    input  wire logic [3:0] timer_out,
    input  wire logic       global_irq_enable,
    // Serial pins
    input  wire logic       sclk_i,
    output logic            sclk_o,
    output logic            sclk_oe,
    input  wire logic       din_i,
    output logic            dout_o,
    output logic            dout_oe,
    // Interrupt request
    output logic            irq_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Outgoing bit of the shifter for the chosen order and width
    function automatic logic out_bit(input logic [15:0] sr,
                                     input logic        lsb,
                                     input logic        wide);
        if (lsb) begin
            out_bit = sr[0];
        end else begin
            out_bit = wide ? sr[15] : sr[7];
        end
    endfunction : out_bit

    // Number of source edges per half period, less one
    function automatic logic [6:0] div_mask(input logic [2:0] div);
        div_mask = 7'((8'h01 << div) - 8'h01);
    endfunction : div_mask

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    shift_spi_pkg::state_t   st_q;
    shift_spi_pkg::state_t   st_d;
    shift_spi_pkg::reg_req_t req;
    shift_spi_pkg::src_sel_t src;

    logic       swrst;
    logic       master;
    logic       phase;
    logic       wide;
    logic       lsb;
    logic       run;
    logic       src_lvl;
    logic       shl;
    logic       rise;
    logic       fall;
    logic       smp_edge;
    logic       out_edge;
    logic       din_bit;
    logic       ok;
    logic       wr_cnt;

    assign req      = '{addr: reg_addr, wdata: reg_wdata,
                        wr: reg_wr, rd: reg_rd};
    assign swrst    = st_q.ctrl0[`B_SOFT_RESET];
    assign master   = st_q.ctrl0[`B_MASTER];
    assign phase    = st_q.ctrl1[`B_PHASE];
    assign wide     = st_q.ctrl1[`B_WIDE];
    assign lsb      = st_q.ctrl0[`B_LSB_FIRST];
    assign src      = shift_spi_pkg::src_sel_t'(st_q.clkctl[`F_SRC_LO +: 3]);
    assign wr_cnt   = req.wr && (req.addr == `OFF_COUNT);

    // ------------------------------------------------------------
    // Clock source selection and shift edges
    // ------------------------------------------------------------
    // mux over synchronised sources, soft bit at code 100
    always_comb begin
        case (src)
            shift_spi_pkg::SRC_AUX:  src_lvl = st_q.s2[0];
            shift_spi_pkg::SRC_SUB:  src_lvl = st_q.s2[1];
            shift_spi_pkg::SRC_PIN:  src_lvl = st_q.s2[2];
            shift_spi_pkg::SRC_TMR0: src_lvl = st_q.s2[4];
            shift_spi_pkg::SRC_SOFT: src_lvl = st_q.clkctl[`B_SOFT_CLK];
            shift_spi_pkg::SRC_TMR1: src_lvl = st_q.s2[5];
            shift_spi_pkg::SRC_TMR2: src_lvl = st_q.s2[6];
            default:                 src_lvl = st_q.s2[4];
        endcase
    end

    // master runs only with done clear and bits left
    assign run      = master && !swrst && !st_q.ctrl1[`B_DONE]
                      && (st_q.cnt != 5'h00);
    // slave takes its shift level from the pin
    assign shl      = master ? st_q.gclk
                             : (st_q.s2[2] ^ st_q.clkctl[`B_POLARITY]);
    assign rise     = shl && !st_q.shl_prev;
    assign fall     = !shl && st_q.shl_prev;
    // phase picks which edge samples and which changes data
    assign smp_edge = phase ? fall : rise;
    assign out_edge = phase ? rise : fall;
    // soft reset freezes shifter and counter
    assign ok       = !swrst && (st_q.cnt != 5'h00);
    // data in counts only when its pin is given to the shifter
    assign din_bit  = st_q.s2[3] && st_q.ctrl0[`B_DIN_PE];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic set_done;
        logic clr_done;
        logic sr_wr;
        set_done = 1'b0;
        clr_done = 1'b0;
        sr_wr    = 1'b0;
        st_d     = st_q;

        // Two-stage synchronisers; only stage two is read
        st_d.s1 = {timer_out[2:0], din_i, sclk_i,
                   subsystem_clock, aux_clk};
        st_d.s2 = st_q.s1;
        st_d.src_prev = src_lvl;
        st_d.shl_prev = shl;

        // count both source edges, toggle every 2^div of them
        if (run) begin
            if (src_lvl != st_q.src_prev) begin
                if (st_q.divcnt >= div_mask(st_q.clkctl[`F_DIV_LO +: 3]))
                begin
                    st_d.divcnt = 7'h00;
                    st_d.gclk   = !st_q.gclk;
                end else begin
                    st_d.divcnt = st_q.divcnt + 7'h01;
                end
            end
        end else begin
            // generated clock parks when done or slave
            st_d.divcnt = 7'h00;
            st_d.gclk   = 1'b0;
        end

        // sample edge shifts one bit in and counts down
        if (smp_edge && ok) begin
            if (lsb) begin
                // width chooses where the new bit enters
                if (wide) begin
                    st_d.sr = {din_bit, st_q.sr[15:1]};
                end else begin
                    st_d.sr = {st_q.sr[15:8], din_bit, st_q.sr[7:1]};
                end
            end else if (wide) begin
                st_d.sr = {st_q.sr[14:0], din_bit};
            end else begin
                st_d.sr = {st_q.sr[15:8], st_q.sr[6:0], din_bit};
            end
            st_d.cnt = st_q.cnt - 5'h01;
            if (st_q.cnt == 5'h01) begin
                set_done = 1'b1;
            end
        end

        // latch follows the shifter on the output edge, or at once on a phase 1 load
        if (out_edge && !swrst) begin
            st_d.latch = out_bit(st_q.sr, lsb, wide);
        end

        // Register writes win over shifting in the same cycle, except that a done set by the last shift beats a done clear
        if (req.wr) begin
            case (req.addr)
                `OFF_CTRL0:  st_d.ctrl0 = req.wdata;
                `OFF_CTRL1: begin
                    st_d.ctrl1[7:3] = req.wdata[7:3];
                    // Flags cleared by writing 0, done may also be set
                    st_d.ctrl1[`B_STOP_SEEN] = st_q.ctrl1[`B_STOP_SEEN]
                                               & req.wdata[`B_STOP_SEEN];
                    st_d.ctrl1[`B_ARB_LOST]  = st_q.ctrl1[`B_ARB_LOST]
                                               & req.wdata[`B_ARB_LOST];
                    if (req.wdata[`B_DONE]) begin
                        set_done = 1'b1;
                    end else begin
                        clr_done = 1'b1;
                    end
                end
                `OFF_CLKCTL: st_d.clkctl = req.wdata;
                `OFF_COUNT: begin
                    st_d.cnt = req.wdata[4:0];
                    if (req.wdata[4:0] == 5'h00) begin
                        set_done = 1'b1;
                    end else if (!st_q.ctrl1[`B_FC_INHIBIT]) begin
                        clr_done = 1'b1;
                    end
                end
                `OFF_SHIFT_LOW: begin
                    st_d.sr[7:0] = req.wdata;
                    sr_wr        = 1'b1;
                end
                `OFF_SHIFT_HIGH: begin
                    st_d.sr[15:8] = req.wdata;
                    sr_wr         = 1'b1;
                end
                default: ;
            endcase
        end

        // with phase 1 a fresh load shows its first bit at once
        if (sr_wr && st_d.ctrl1[`B_PHASE]) begin
            st_d.latch = out_bit(st_d.sr, st_d.ctrl0[`B_LSB_FIRST],
                                 st_d.ctrl1[`B_WIDE]);
        end

        // Set wins over a clear in the same cycle
        st_d.ctrl1[`B_DONE] = set_done
                              | (st_q.ctrl1[`B_DONE] & !clr_done);

        // flags held cleared during soft reset
        if (swrst) begin
            st_d.ctrl1[`B_DONE]      = 1'b0;
            st_d.ctrl1[`B_STOP_SEEN] = 1'b0;
            st_d.ctrl1[`B_ARB_LOST]  = 1'b0;
            st_d.start_seen          = 1'b0;
        end

        // Read data valid in the cycle after the strobe only
        st_d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `OFF_CTRL0:      st_d.rdata = st_q.ctrl0;
                `OFF_CTRL1:      st_d.rdata = st_q.ctrl1;
                `OFF_CLKCTL:     st_d.rdata = st_q.clkctl;
                `OFF_COUNT:      st_d.rdata = {3'h0, st_q.cnt};
                `OFF_SHIFT_LOW:  st_d.rdata = st_q.sr[7:0];
                `OFF_SHIFT_HIGH: st_d.rdata = st_q.sr[15:8];
                // pin levels readable whatever the enables
                `OFF_STATUS:     st_d.rdata = {4'h0, st_q.irq,
                                   st_q.start_seen, st_q.s2[3], st_q.s2[2]};
                default:         st_d.rdata = 8'h00;
            endcase
        end

        // transparent latch passes the shifter bit straight out
        st_d.dout = st_d.ctrl0[`B_LATCH_TRANSP]
                    ? out_bit(st_d.sr, st_d.ctrl0[`B_LSB_FIRST],
                              st_d.ctrl1[`B_WIDE])
                    : st_d.latch;
        // data out driven only with its enable bit and pin
        st_d.dout_oe = st_d.ctrl0[`B_DOUT_OE] && st_d.ctrl0[`B_DOUT_PE];
        // idle level from polarity, toggling while running
        st_d.sclk = st_d.gclk ^ st_d.clkctl[`B_POLARITY];
        // master owns the clock pin; two-wire soft reset lets go
        st_d.sclk_oe = st_d.ctrl0[`B_CLK_PE] && st_d.ctrl0[`B_MASTER]
                       && !(st_d.ctrl1[`B_TWO_WIRE]
                            && st_d.ctrl0[`B_SOFT_RESET]);
        st_d.irq = st_d.ctrl1[`B_DONE] && st_d.ctrl1[`B_IRQ_EN]
                   && global_irq_enable;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q        <= '0;
            st_q.ctrl0  <= `RST_CTRL0;
            st_q.ctrl1  <= `RST_CTRL1;
            st_q.clkctl <= `RST_CLKCTL;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign dout_o    = st_q.dout;
    assign dout_oe   = st_q.dout_oe;
    assign sclk_o    = st_q.sclk;
    assign sclk_oe   = st_q.sclk_oe;
    assign irq_o     = st_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_ZERO_WRITE_SETS: assert property (
        wr_cnt && req.wdata[4:0] == 5'h00 && !swrst
        && !st_d.ctrl0[`B_SOFT_RESET]
        |=> st_q.ctrl1[`B_DONE])
        else $error("zero count write did not set done");

    AST_INHIBIT_KEEPS: assert property (
        wr_cnt && req.wdata[4:0] != 5'h00 && st_q.ctrl1[`B_FC_INHIBIT]
        && st_q.ctrl1[`B_DONE] && !swrst
        |=> st_q.ctrl1[`B_DONE])
        else $error("inhibited count write cleared done");

    AST_NO_WRAP: assert property (
        st_q.cnt == 5'h00 && !wr_cnt |=> st_q.cnt == 5'h00)
        else $error("bit counter wrapped");

    AST_SHIFT_COUNTS: assert property (
        smp_edge && ok && !wr_cnt
        |=> st_q.cnt == $past(st_q.cnt) - 5'h01)
        else $error("sample edge did not decrement count");

    AST_LATCH_HOLDS: assert property (
        !out_edge && !(req.wr && (req.addr == `OFF_SHIFT_LOW
                                  || req.addr == `OFF_SHIFT_HIGH))
        |=> $stable(st_q.latch))
        else $error("latch moved off the output edge");

    AST_TRANSPARENT: assert property (
        st_q.ctrl0[`B_LATCH_TRANSP]
        |-> dout_o == out_bit(st_q.sr, lsb, wide))
        else $error("transparent latch not showing shifter bit");

    AST_SWRST_FLAGS: assert property (
        swrst |=> !st_q.ctrl1[`B_DONE] && !st_q.ctrl1[`B_ARB_LOST]
                  && !st_q.ctrl1[`B_STOP_SEEN])
        else $error("flag set during soft reset");

    AST_GEN_STOPS: assert property (
        !run |=> !st_q.gclk ##1 !st_q.gclk || run)
        else $error("generated clock ran while stopped");

    AST_IDLE_LEVEL: assert property (
        !st_q.gclk |-> sclk_o == st_q.clkctl[`B_POLARITY])
        else $error("clock not at polarity idle level");

    AST_DOUT_OE: assert property (
        !st_q.ctrl0[`B_DOUT_OE] |-> !dout_oe)
        else $error("data out driven without enable");

    AST_IRQ: assert property (
        st_q.ctrl1[`B_DONE] && st_q.ctrl1[`B_IRQ_EN] && global_irq_enable
        && !swrst |=> irq_o || !st_q.ctrl1[`B_DONE])
        else $error("interrupt missing for done flag");

    COV_MASTER_DONE: cover property (
        master && run ##[1:1000] st_q.ctrl1[`B_DONE]);
    COV_SLAVE_SHIFT: cover property (!master && smp_edge && ok);
    COV_TRANSP: cover property (st_q.ctrl0[`B_LATCH_TRANSP] && dout_oe);

endmodule : shift_spi

// ==== core/shift_spi_defines.svh ====
// Offsets, field positions, reset values and widths of the serial shifter
`ifndef SHIFT_SPI_DEFINES_SVH
`define SHIFT_SPI_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_CTRL0      3'h0
`define OFF_CTRL1      3'h1
`define OFF_CLKCTL     3'h2
`define OFF_COUNT      3'h3
`define OFF_SHIFT_LOW  3'h4
`define OFF_SHIFT_HIGH 3'h5
`define OFF_STATUS     3'h6

// ----------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------
`define B_SOFT_RESET   0
`define B_DOUT_OE      1
`define B_LATCH_TRANSP 2
`define B_MASTER       3
`define B_LSB_FIRST    4
`define B_CLK_PE       5
`define B_DOUT_PE      6
`define B_DIN_PE       7

// ----------------------------------------------------------------
// Control register 1 fields
// ----------------------------------------------------------------
`define B_DONE         0
`define B_STOP_SEEN    1
`define B_ARB_LOST     2
`define B_FC_INHIBIT   3
`define B_IRQ_EN       4
`define B_WIDE         5
`define B_TWO_WIRE     6
`define B_PHASE        7
`define B_START_SEEN   0

// ----------------------------------------------------------------
// Clock control fields
// ----------------------------------------------------------------
`define B_SOFT_CLK     0
`define B_POLARITY     1
`define F_SRC_LO       2
`define F_DIV_LO       5

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RST_CTRL0      8'h01
`define RST_CTRL1      8'h00
`define RST_CLKCTL     8'h00
`define CNT_W          5
`define SRC_SOFT       3'h4
`define NUM_SYNC       7

`endif

// ==== core/shift_spi_pkg.sv ====
// Types shared by the serial shifter design
package shift_spi_pkg;

    // ------------------------------------------------------------
    // Clock source selection codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_AUX  = 3'h0,
        SRC_SUB  = 3'h1,
        SRC_PIN  = 3'h2,
        SRC_TMR0 = 3'h3,
        SRC_SOFT = 3'h4,
        SRC_TMR1 = 3'h5,
        SRC_TMR2 = 3'h6,
        SRC_TMR3 = 3'h7
    } src_sel_t;

    // ------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // ------------------------------------------------------------
    // Whole state of the shifter
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [7:0]  clkctl;
        logic        start_seen;
        logic [4:0]  cnt;
        logic [15:0] sr;
        logic        latch;
        logic        gclk;
        logic [6:0]  divcnt;
        logic        src_prev;
        logic        shl_prev;
        logic [6:0]  s1;
        logic [6:0]  s2;
        logic [7:0]  rdata;
        logic        dout;
        logic        dout_oe;
        logic        sclk;
        logic        sclk_oe;
        logic        irq;
    } state_t;

endpackage : shift_spi_pkg
